// file: sics_pkg.sv
// shared constants and types for the step interpolator and current scaler
// Operation
// - with interpolation on, each step edge yields 16 fine microsteps at 256x resolution
// - interpolation works only while the interpolation enable control bit is set
// - time the last step interval; space the next 16 microsteps at one sixteenth
// - interval counter spans 2^20 clocks; overrun sets the idle flag
// - idle flag clears on the next active step edge
// - new rate takes effect only after one full period is measured
// - new step edge abandons unfinished microsteps of the current burst
// - standalone input halves the coil current while standing still
// - sense range bit 0 selects 325 mV, 1 selects 173 mV full scale
// - both coil targets scale by (scale+1)/32 from a 5-bit field
// - target equals coil value over 248 times scale factor times full scale
// - effective scale is adapted scale clamped 0..31, capped by programmed scale
// - coil values come from serial settings or from the sine table
// - each microstep moves the 10-bit angle up when dir is 0, down when 1
package sics_pkg;
  localparam int           IVL_W        = 20;
  localparam logic [19:0]  IVL_MAX      = 20'hFFFFF;
  localparam int           SUB_STEPS    = 16;
  localparam int           SUB_SHIFT    = 4;
  localparam int           ANGLE_W      = 10;
  localparam logic [9:0]   FINE_INC     = 10'h001;
  localparam int           COIL_W       = 9;
  localparam int           SCALE_W      = 5;
  localparam logic [4:0]   SCALE_MAX    = 5'h1F;
  localparam logic [8:0]   TABLE_AMPL   = 9'h0F8;
  localparam int           FS_LOW_MV    = 325;
  localparam int           FS_HIGH_MV   = 173;
  localparam logic [8:0]   FS_LOW_CODE  = 9'(FS_LOW_MV);
  localparam logic [8:0]   FS_HIGH_CODE = 9'(FS_HIGH_MV);
  localparam int           TGT_W        = 18;
  typedef enum logic [2:0] {
    SICS_IDLE  = 3'b001,
    SICS_BURST = 3'b010,
    SICS_HOLD  = 3'b100
  } sics_state_t;
endpackage

// file: sics_scale_if.sv
// interface carrying coil values and scale settings to the scaler
`timescale 1ns/10ps
interface sics_scale_if;
  logic signed [8:0] coil_a;
  logic signed [8:0] coil_b;
  logic        [4:0] scale;
  logic              range_high;
  logic              halve;
  logic signed [17:0] target_a;
  logic signed [17:0] target_b;
  modport src (output coil_a, coil_b, scale, range_high, halve, input target_a, target_b);
  modport scl (input coil_a, coil_b, scale, range_high, halve, output target_a, target_b);
endinterface

// file: sics_scaler.sv
// coil target scaler: value/248 * (scale+1)/32 * full scale in mV
`timescale 1ns/10ps
module sics_scaler
(
  input  wire logic mclk,
  input  wire logic reset,
  sics_scale_if.scl sif
);
  logic signed [17:0] tgt_a_ff;
  logic signed [17:0] tgt_b_ff;

  function automatic logic signed [17:0] scale_one(input logic signed [8:0] v,
                                                 input logic [4:0] s,
                                                 input logic [8:0] fs,
                                                 input logic hv);
    logic signed [31:0] p;
    p = 32'(v) * $signed(32'(s + 6'h01)) * $signed(32'(fs));
    p = p / $signed(32'(sics_pkg::TABLE_AMPL) * 32'h20);
    if (hv)
      p = p >>> 1;
    return 18'(p);
  endfunction

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tgt_a_ff <= 18'h00000;
      tgt_b_ff <= 18'h00000;
    end
    else
    begin
      tgt_a_ff <= scale_one(sif.coil_a, sif.scale,
                            sif.range_high ? sics_pkg::FS_HIGH_CODE : sics_pkg::FS_LOW_CODE,
                            sif.halve);
      tgt_b_ff <= scale_one(sif.coil_b, sif.scale,
                            sif.range_high ? sics_pkg::FS_HIGH_CODE : sics_pkg::FS_LOW_CODE,
                            sif.halve);
    end
  end

  assign sif.target_a = tgt_a_ff;
  assign sif.target_b = tgt_b_ff;
endmodule

// file: sics_top.sv
// step interpolator with microstep angle counter and coil current scaling
`timescale 1ns/10ps
module sics_top
#(
  parameter int IVL_LIMIT = 1048575
)
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              step_in,
  input  wire logic              dir_in,
  input  wire logic              interp_enable,
  input  wire logic              both_edge_mode,
  input  wire logic [9:0]        coarse_inc,
  input  wire logic              serial_mode,
  input  wire logic signed [8:0] serial_coil_a,
  input  wire logic signed [8:0] serial_coil_b,
  input  wire logic signed [8:0] table_coil_a,
  input  wire logic signed [8:0] table_coil_b,
  input  wire logic [4:0]        scale_prog,
  input  wire logic signed [5:0] scale_adjust,
  input  wire logic              sense_range_select,
  input  wire logic              standalone_halve,
  output logic [9:0]             microangle_index,
  output logic                   idle_flag,
  output logic                   microstep_pulse,
  output logic [4:0]             scale_eff,
  output logic signed [17:0]     target_a,
  output logic signed [17:0]     target_b
);
  if (IVL_LIMIT < 32 || IVL_LIMIT > 1048575)
  begin : g_bad_limit
    $error("IVL_LIMIT out of range");
  end

  if (sics_pkg::SUB_STEPS != (1 << sics_pkg::SUB_SHIFT))
  begin : g_bad_sub
    $error("SUB_STEPS must equal two to the power SUB_SHIFT");
  end

  if (sics_pkg::IVL_W != 20 || sics_pkg::ANGLE_W != 10)
  begin : g_bad_width
    $error("interval and angle counters are fixed at 20 and 10 bits");
  end

  localparam logic [19:0] LIM = 20'(IVL_LIMIT);

  logic [2:0]  step_sync_ff;
  logic        dir_s1_ff;
  logic        dir_s2_ff;
  logic        step_edge;
  logic [19:0] ivl_cnt_ff;
  logic [19:0] spacing_ff;
  logic [19:0] gap_cnt_ff;
  logic [4:0]  left_ff;
  logic [9:0]  angle_ff;
  logic        idle_ff;
  logic        pulse_ff;
  logic [4:0]  scale_ff;
  logic        fine_tick;
  sics_pkg::sics_state_t state_ff;
  sics_pkg::sics_state_t nxt_state;
  sics_scale_if sif ();

  // step and dir synchronisers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      step_sync_ff <= 3'h0;
      dir_s1_ff    <= 1'b0;
      dir_s2_ff    <= 1'b0;
    end
    else
    begin
      step_sync_ff <= {step_sync_ff[1:0], step_in};
      dir_s1_ff    <= dir_in;
      dir_s2_ff    <= dir_s1_ff;
    end
  end

  assign step_edge = both_edge_mode ? (step_sync_ff[2] ^ step_sync_ff[1])
                                    : (step_sync_ff[1] & ~step_sync_ff[2]);

  // interval timer, saturating
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ivl_cnt_ff  <= 20'h00000;
    end
    else if (step_edge)
    begin
      ivl_cnt_ff  <= 20'h00001;
    end
    else if (ivl_cnt_ff != LIM)
      ivl_cnt_ff <= ivl_cnt_ff + 20'h00001;
  end

  // idle flag: set on overrun, cleared by next edge; clear wins
  always_ff @(posedge mclk)
  begin
    if (reset)
      idle_ff <= 1'b0;
    else if (ivl_cnt_ff == LIM && !step_edge)
      idle_ff <= 1'b1;
    else if (step_edge)
      idle_ff <= 1'b0;
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      sics_pkg::SICS_IDLE:
        if (step_edge && interp_enable)
          nxt_state = sics_pkg::SICS_BURST;
      sics_pkg::SICS_BURST:
        if (!interp_enable)
          nxt_state = sics_pkg::SICS_IDLE;
        else if (!step_edge && fine_tick && left_ff == 5'h01)
          nxt_state = sics_pkg::SICS_HOLD;
      sics_pkg::SICS_HOLD:
        if (!interp_enable)
          nxt_state = sics_pkg::SICS_IDLE;
        else if (step_edge)
          nxt_state = sics_pkg::SICS_BURST;
      default:
        nxt_state = sics_pkg::SICS_IDLE;
    endcase
  end

  assign fine_tick = (state_ff == sics_pkg::SICS_BURST) && (gap_cnt_ff == 20'h00000);

  // burst sequencer: restart on each edge, abandoning leftovers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_ff   <= sics_pkg::SICS_IDLE;
      spacing_ff <= 20'h00001;
      gap_cnt_ff <= 20'h00000;
      left_ff    <= 5'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      if (step_edge)
      begin
        spacing_ff <= (ivl_cnt_ff >> sics_pkg::SUB_SHIFT) == 20'h00000 ? 20'h00001
                      : (ivl_cnt_ff >> sics_pkg::SUB_SHIFT);
        gap_cnt_ff <= 20'h00000;
        left_ff    <= 5'(sics_pkg::SUB_STEPS);
      end
      else if (fine_tick)
      begin
        gap_cnt_ff <= spacing_ff - 20'h00001;
        left_ff    <= left_ff - 5'h01;
      end
      else if (gap_cnt_ff != 20'h00000)
        gap_cnt_ff <= gap_cnt_ff - 20'h00001;
    end
  end

  // angle counter
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      angle_ff <= 10'h000;
      pulse_ff <= 1'b0;
    end
    else
    begin
      pulse_ff <= 1'b0;
      if (fine_tick && !step_edge)
      begin
        pulse_ff <= 1'b1;
        angle_ff <= dir_s2_ff ? angle_ff - sics_pkg::FINE_INC
                              : angle_ff + sics_pkg::FINE_INC;
      end
      else if (step_edge && !interp_enable)
      begin
        pulse_ff <= 1'b1;
        angle_ff <= dir_s2_ff ? angle_ff - coarse_inc : angle_ff + coarse_inc;
      end
    end
  end

  // effective scale: programmed plus adjust, clamped to 0..programmed
  always_ff @(posedge mclk)
  begin
    if (reset)
      scale_ff <= sics_pkg::SCALE_MAX;
    else if ($signed({1'b0, scale_prog}) + scale_adjust < 7'sd0)
      scale_ff <= 5'h00;
    else if (scale_adjust > 6'sd0)
      scale_ff <= scale_prog;
    else
      scale_ff <= 5'($signed({1'b0, scale_prog}) + scale_adjust);
  end

  assign sif.coil_a     = serial_mode ? serial_coil_a : table_coil_a;
  assign sif.coil_b     = serial_mode ? serial_coil_b : table_coil_b;
  assign sif.scale      = scale_ff;
  assign sif.range_high = sense_range_select;
  assign sif.halve      = standalone_halve & idle_ff;

  sics_scaler u_scaler
  (
    .mclk  (mclk),
    .reset (reset),
    .sif   (sif)
  );

  assign microangle_index = angle_ff;
  assign idle_flag        = idle_ff;
  assign microstep_pulse  = pulse_ff;
  assign scale_eff        = scale_ff;
  assign target_a         = sif.target_a;
  assign target_b         = sif.target_b;
endmodule

// file: sics_top_sva.sv
// assertion checker for the step interpolator top
`timescale 1ns/10ps
module sics_chk
#(
  parameter int IVL_LIMIT = 1048575
)
(
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              step_in,
  input wire logic              dir_in,
  input wire logic              interp_enable,
  input wire logic              both_edge_mode,
  input wire logic [4:0]        scale_prog,
  input wire logic signed [5:0] scale_adjust,
  input wire logic [9:0]        microangle_index,
  input wire logic              idle_flag,
  input wire logic              microstep_pulse,
  input wire logic [4:0]        scale_eff
);
  logic [20:0] since_ff;
  logic [3:0]  sdly_ff;
  logic [4:0]  pcnt_ff;
  wire raw_edge = (step_in & ~sdly_ff[0]) | (both_edge_mode & ~step_in & sdly_ff[0]);
  wire int_edge = (sdly_ff[2] & ~sdly_ff[3]) | (both_edge_mode & (sdly_ff[2] ^ sdly_ff[3]));
  always_ff @(posedge mclk) sdly_ff <= {sdly_ff[2:0], step_in};
  always_ff @(posedge mclk)
    if (reset || raw_edge) since_ff <= '0;
    else if (~&since_ff) since_ff <= since_ff + 21'h000001;
  // pulses since the last synchronised edge, one pulse of slack for abandoned ones
  always_ff @(posedge mclk)
    if (reset || int_edge) pcnt_ff <= '0;
    else pcnt_ff <= pcnt_ff + {4'h0, microstep_pulse};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence edge_while_idle; idle_flag && raw_edge; endsequence
  sequence steady_up; interp_enable && $past(interp_enable, 4) && !dir_in && !$past(dir_in, 4); endsequence
  sequence steady_dn; interp_enable && $past(interp_enable, 4) && dir_in && $past(dir_in, 4); endsequence
  angle_needs_pulse_a: assert property ($changed(microangle_index) |-> microstep_pulse) else $error("angle moved without pulse");
  fine_up_a: assert property ((microstep_pulse and steady_up) |->
    microangle_index == $past(microangle_index) + sics_pkg::FINE_INC)
    else $error("fine step up wrong");
  fine_down_a: assert property ((microstep_pulse and steady_dn) |->
    microangle_index == $past(microangle_index) - sics_pkg::FINE_INC)
    else $error("fine step down wrong");
  idle_set_a: assert property (since_ff > 21'(IVL_LIMIT + 8) |-> idle_flag) else $error("idle flag missing");
  idle_clear_a: assert property (edge_while_idle |-> ##[2:6] !idle_flag) else $error("idle flag not cleared");
  burst_max_a: assert property (pcnt_ff <= 5'h11) else $error("too many microsteps");
  coarse_single_a: assert property (microstep_pulse && !interp_enable && !$past(interp_enable) |=> !microstep_pulse) else $error("coarse step repeated");
  scale_full_a: assert property (!$past(reset) && $stable(scale_prog) && $stable(scale_adjust) && !scale_adjust[5] |-> scale_eff == scale_prog) else $error("scale not programmed value");
endmodule
bind sics_top sics_chk #(.IVL_LIMIT(IVL_LIMIT)) chk (.mclk(mclk), .reset(reset), .step_in(step_in),
  .dir_in(dir_in), .interp_enable(interp_enable), .both_edge_mode(both_edge_mode), .scale_prog(scale_prog),
  .scale_adjust(scale_adjust), .microangle_index(microangle_index), .idle_flag(idle_flag),
  .microstep_pulse(microstep_pulse), .scale_eff(scale_eff));

// file: sics_step_gen.sv
// step source with steady rate and even duty
`timescale 1ns/10ps
module sics_step_gen
(
  input  wire logic        mclk,
  input  wire logic        run,
  input  wire logic [15:0] half,
  output logic             step
);
  logic [15:0] cnt_ff;
  initial step = 1'b0;
  initial cnt_ff = 16'h0000;
  // square wave, holds its level while stopped
  always @(negedge mclk)
    if (!run) cnt_ff <= 16'h0000;
    else if (cnt_ff + 16'h0001 >= half)
    begin
      cnt_ff <= 16'h0000;
      step <= ~step;
    end
    else cnt_ff <= cnt_ff + 16'h0001;
endmodule

// file: sics_top_tb.sv
// self-checking bench for the step interpolator and current scaler
`timescale 1ns/10ps
module sics_top_tb;
  typedef struct packed {logic [4:0] prog; logic [5:0] adj; logic rng; logic ser; logic [4:0] eff;} sics_row_t;
  sics_row_t rows [6] = '{'{5'h1F, 6'h00, 1'b0, 1'b1, 5'h1F}, '{5'h1F, 6'h00, 1'b1, 1'b0, 5'h1F},
    '{5'h0F, 6'h05, 1'b0, 1'b1, 5'h0F}, '{5'h0F, 6'h3C, 1'b1, 1'b1, 5'h0B},
    '{5'h03, 6'h37, 1'b0, 1'b0, 5'h00}, '{5'h00, 6'h00, 1'b1, 1'b0, 5'h00}};
  logic mclk = 1'b0, reset = 1'b1, dir_in = 1'b0, interp_enable = 1'b1, run = 1'b0, serial_mode = 1'b1;
  logic sense_range_select = 1'b0, standalone_halve = 1'b0, both_edge_mode = 1'b0, step_in;
  logic [4:0] scale_prog = 5'h1F, scale_eff;
  logic signed [5:0] scale_adjust = 6'h00;
  logic [9:0] coarse_inc = 10'h040, microangle_index;
  logic [15:0] half = 16'h0050;
  logic idle_flag, microstep_pulse;
  logic signed [17:0] target_a, target_b;
  int n_errors = 0, samples_checked = 0, pc = 0, cyc = 0, lastp = 0, gap = 0, np;
  logic [9:0] da;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (microstep_pulse === 1'b1)
    begin
      pc <= pc + 1;
      gap <= cyc - lastp;
      lastp <= cyc;
    end
  end
  sics_step_gen gen (.mclk(mclk), .run(run), .half(half), .step(step_in));
  sics_top #(.IVL_LIMIT(200)) DUT (.mclk(mclk), .reset(reset), .step_in(step_in), .dir_in(dir_in),
    .interp_enable(interp_enable), .both_edge_mode(both_edge_mode), .coarse_inc(coarse_inc),
    .serial_mode(serial_mode), .serial_coil_a(9'sh0F8), .serial_coil_b(9'sh0BA),
    .table_coil_a(9'sh07C), .table_coil_b(9'sh03E), .scale_prog(scale_prog),
    .scale_adjust(scale_adjust), .sense_range_select(sense_range_select),
    .standalone_halve(standalone_halve), .microangle_index(microangle_index), .idle_flag(idle_flag),
    .microstep_pulse(microstep_pulse), .scale_eff(scale_eff), .target_a(target_a), .target_b(target_b));
  function automatic logic [17:0] tgt(input int coil, input int eff, input logic rng, input logic hv);
    int v;
    v = coil * (eff + 1) * (rng ? sics_pkg::FS_HIGH_MV : sics_pkg::FS_LOW_MV);
    v = v / (int'(sics_pkg::TABLE_AMPL) * 32);
    return hv ? 18'(v / 2) : 18'(v);
  endfunction
  task automatic tally_and_finish(input bit hung);
    if (hung) n_errors++;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wait_rise;
    int k;
    logic p;
    p = step_in;
    for (k = 0; k < 1000 && !(step_in && !p); k++)
    begin
      p = step_in;
      @(posedge mclk);
      #1;
    end
    if (k == 1000) tally_and_finish(1);
  endtask
  // pulses and angle travel from now to the next rising step
  task automatic period(output int n, output logic [9:0] d);
    int p0;
    logic [9:0] a0;
    p0 = pc;
    a0 = microangle_index;
    wait_rise;
    n = pc - p0;
    d = microangle_index - a0;
  endtask
  initial
  begin
    repeat (16) @(negedge mclk);
    cmp("angle", 10'h000, microangle_index);
    cmp("idle", 1'b0, idle_flag);
    cmp("scale_eff", 5'h1F, scale_eff);
    cmp("target_a", 18'h00000, target_a);
    reset = 1'b0;
    foreach (rows[i])
    begin
      {scale_prog, scale_adjust, sense_range_select, serial_mode} = rows[i][17:5];
      repeat (4) @(negedge mclk);
      cmp("scale_eff", rows[i].eff, scale_eff);
      cmp("target_a", tgt(rows[i].ser ? 248 : 124, rows[i].eff, rows[i].rng, 0), target_a);
      cmp("target_b", tgt(rows[i].ser ? 186 : 62, rows[i].eff, rows[i].rng, 0), target_b);
    end
    {scale_prog, scale_adjust, sense_range_select, serial_mode} = 13'h1F01;
    run = 1'b1;
    wait_rise;
    repeat (3) period(np, da);
    cmp("burst_pulses", 16, np);
    cmp("burst_angle", 10'h010, da);
    cmp("spacing", 10, gap);
    @(negedge mclk) dir_in = 1'b1;
    period(np, da);
    cmp("down_angle", 10'h3F0, da);
    @(negedge mclk) half = 16'h0028;
    period(np, da);
    cmp("cut_burst", 8, np);
    period(np, da);
    cmp("fast_burst", 16, np);
    cmp("fast_spacing", 5, gap);
    @(negedge mclk) run = 1'b0;
    for (int k = 0; k < 400 && idle_flag !== 1'b1; k++) @(negedge mclk);
    cmp("idle", 1'b1, idle_flag);
    standalone_halve = 1'b1;
    repeat (4) @(negedge mclk);
    cmp("halved", tgt(248, 31, 1'b0, 1'b1), target_a);
    run = 1'b1;
    wait_rise;
    repeat (8) @(negedge mclk);
    cmp("idle", 1'b0, idle_flag);
    interp_enable = 1'b0;
    wait_rise;
    period(np, da);
    cmp("coarse_pulses", 1, np);
    cmp("coarse_angle", 10'h3C0, da);
    @(negedge mclk);
    interp_enable = 1'b1;
    both_edge_mode = 1'b1;
    period(np, da);
    period(np, da);
    cmp("dual_pulses", 32, np);
    cmp("dual_angle", 10'h3E0, da);
    tally_and_finish(0);
  end
endmodule
